// >>> logic/oam_pkg.sv
// shared constants and types for the operand address mode block
package oam_pkg;
  localparam int DATA_W = 16;
  localparam logic [3:0] REG_PROGRAM_COUNTER = 4'h0;
  localparam logic [3:0] REG_STATUS_REGISTER = 4'h2;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] ZERO_BASE = 16'h0000;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [1:0] SRC_MODE_REGISTER = 2'h0;
  localparam logic [1:0] SRC_MODE_INDEXED = 2'h1;
  localparam logic DST_MODE_REGISTER = 1'b0;
  localparam logic DST_MODE_INDEXED = 1'b1;
  localparam int BYTE_SIGN_BIT = 7;
  localparam int WORD_SIGN_BIT = 15;
  localparam logic [7:0] HIGH_BYTE_CLEAR = 8'h00;
  localparam logic [1:0] ONE_WORD = 2'h1;

  typedef enum logic [1:0] {
    OAM_IDLE = 2'b00,
    OAM_SRC_EXT = 2'b01,
    OAM_DST_EXT = 2'b11,
    OAM_DONE = 2'b10
  } oam_state_t;
endpackage

// >>> logic/oam_operand_addr.sv
// operand address generation for register, indexed, symbolic and absolute modes
//
// Summary of operation
// - a byte instruction that writes a register clears the upper eight result bits.
// - byte instructions take their status flags from the byte-wide result.
// - the four modes are accepted for both the source and the destination operand.
// - indexed address is base register plus offset word, and base registers stay untouched.
// - the program counter steps past every fetched offset word.
// - an instruction takes one word plus one extension word per memory operand.
// - symbolic address is the extension word plus the program counter at that word.
// - symbolic extension words are also stepped over before the next instruction.
// - absolute mode is indexed through the status register, which gives a zero base.
// - source field 00 or destination bit 0 is register mode, 01 or 1 the indexed family.
`timescale 1ns/1ps
module oam_operand_addr
  import oam_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic [oam_pkg::DATA_W-1:0] instrPc,
  input wire logic [1:0] sourceModeField,
  input wire logic [3:0] srcRegSel,
  input wire logic [oam_pkg::DATA_W-1:0] srcRegVal,
  input wire logic dstModeBit,
  input wire logic [3:0] dstRegSel,
  input wire logic [oam_pkg::DATA_W-1:0] dstRegVal,
  output logic fetchReq,
  output logic [oam_pkg::DATA_W-1:0] fetchAddr,
  input wire logic [oam_pkg::DATA_W-1:0] fetchData,
  input wire logic fetchAck,
  output logic busy,
  output logic done,
  output logic unsupportedMode,
  output logic srcIsMem,
  output logic dstIsMem,
  output logic [oam_pkg::DATA_W-1:0] srcAddr,
  output logic [oam_pkg::DATA_W-1:0] dstAddr,
  output logic [oam_pkg::DATA_W-1:0] nextPc,
  output logic [1:0] instrWords,
  input wire logic resultValid,
  input wire logic byteOp,
  input wire logic [oam_pkg::DATA_W-1:0] aluResult,
  input wire logic carryWord,
  input wire logic carryByte,
  input wire logic overflowWord,
  input wire logic overflowByte,
  output logic [oam_pkg::DATA_W-1:0] resultData,
  output logic flagN,
  output logic flagZ,
  output logic flagC,
  output logic flagV
);

  ////////////////////////////////////////////////////////////////////////////
  // base selection: program counter gives symbolic, status register absolute

  function automatic logic [DATA_W-1:0] pick_base(
    input logic [3:0] sel,
    input logic [DATA_W-1:0] regVal,
    input logic [DATA_W-1:0] extPc
  );
    logic [DATA_W-1:0] b;
    b = regVal;
    if (sel == REG_PROGRAM_COUNTER) begin
      b = extPc;
    end else if (sel == REG_STATUS_REGISTER) begin
      b = ZERO_BASE;
    end
    return b;
  endfunction

  oam_state_t state_r, state_nxt;
  logic [DATA_W-1:0] ptr_r, ptr_nxt;
  logic [DATA_W-1:0] srcAddr_r, srcAddr_nxt;
  logic [DATA_W-1:0] dstAddr_r, dstAddr_nxt;
  logic [3:0] srcSel_r, dstSel_r;
  logic [DATA_W-1:0] srcBase_r, dstBase_r;
  logic srcMem_r, dstMem_r, badMode_r;
  logic [1:0] words_r;
  logic [DATA_W-1:0] resultData_r;
  logic flagN_r, flagZ_r, flagC_r, flagV_r;

  wire logic srcNeedsExt = (sourceModeField == SRC_MODE_INDEXED);
  wire logic srcModeBad = (sourceModeField != SRC_MODE_INDEXED) &&
                          (sourceModeField != SRC_MODE_REGISTER);
  wire logic dstNeedsExt = (dstModeBit == DST_MODE_INDEXED);
  wire logic extTaken = fetchReq && fetchAck;
  wire logic [DATA_W-1:0] ptrStep = ptr_r + WORD_STEP;
  // base registers are only read, never written back
  wire logic [DATA_W-1:0] srcExtAddr = pick_base(srcSel_r, srcBase_r, ptr_r) + fetchData;
  wire logic [DATA_W-1:0] dstExtAddr = pick_base(dstSel_r, dstBase_r, ptr_r) + fetchData;
  wire logic [DATA_W-1:0] firstPtr = instrPc + WORD_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing of extension word fetches

  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    srcAddr_nxt = srcAddr_r;
    dstAddr_nxt = dstAddr_r;
    case (state_r)
      OAM_IDLE: begin
        if (start) begin
          ptr_nxt = firstPtr;
          srcAddr_nxt = srcRegVal;
          dstAddr_nxt = dstRegVal;
          if (srcNeedsExt) begin
            state_nxt = OAM_SRC_EXT;
          end else if (dstNeedsExt) begin
            state_nxt = OAM_DST_EXT;
          end else begin
            state_nxt = OAM_DONE;
          end
        end
      end
      OAM_SRC_EXT: begin
        if (extTaken) begin
          srcAddr_nxt = srcExtAddr;
          ptr_nxt = ptrStep;
          state_nxt = dstMem_r ? OAM_DST_EXT : OAM_DONE;
        end
      end
      OAM_DST_EXT: begin
        if (extTaken) begin
          dstAddr_nxt = dstExtAddr;
          ptr_nxt = ptrStep;
          state_nxt = OAM_DONE;
        end
      end
      OAM_DONE: begin
        state_nxt = OAM_IDLE;
      end
      default: begin
        state_nxt = OAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= OAM_IDLE;
      ptr_r <= RESET_WORD;
      srcAddr_r <= RESET_WORD;
      dstAddr_r <= RESET_WORD;
    end else if (ce) begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      srcAddr_r <= srcAddr_nxt;
      dstAddr_r <= dstAddr_nxt;
    end
  end

  // operand description captured at start; an extension word per memory operand
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      srcSel_r <= 4'h0;
      dstSel_r <= 4'h0;
      srcBase_r <= RESET_WORD;
      dstBase_r <= RESET_WORD;
      srcMem_r <= 1'b0;
      dstMem_r <= 1'b0;
      badMode_r <= 1'b0;
      words_r <= ONE_WORD;
    end else if (ce && state_r == OAM_IDLE && start) begin
      srcSel_r <= srcRegSel;
      dstSel_r <= dstRegSel;
      srcBase_r <= srcRegVal;
      dstBase_r <= dstRegVal;
      srcMem_r <= srcNeedsExt;
      dstMem_r <= dstNeedsExt;
      badMode_r <= srcModeBad;
      words_r <= ONE_WORD + {1'b0, srcNeedsExt} + {1'b0, dstNeedsExt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result write-back and flags

  wire logic [DATA_W-1:0] byteResult = {HIGH_BYTE_CLEAR, aluResult[7:0]};
  wire logic [DATA_W-1:0] finalResult = byteOp ? byteResult : aluResult;
  wire logic resNeg = byteOp ? aluResult[BYTE_SIGN_BIT] : aluResult[WORD_SIGN_BIT];
  wire logic resZero = byteOp ? (aluResult[7:0] == 8'h00) : (aluResult == 16'h0000);
  wire logic resCarry = byteOp ? carryByte : carryWord;
  wire logic resOvf = byteOp ? overflowByte : overflowWord;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resultData_r <= RESET_WORD;
      flagN_r <= 1'b0;
      flagZ_r <= 1'b0;
      flagC_r <= 1'b0;
      flagV_r <= 1'b0;
    end else if (ce && resultValid) begin
      resultData_r <= finalResult;
      flagN_r <= resNeg;
      flagZ_r <= resZero;
      flagC_r <= resCarry;
      flagV_r <= resOvf;
    end
  end

  // ce low also holds off the fetch request so no word is taken while frozen
  assign fetchReq = ce && (state_r == OAM_SRC_EXT || state_r == OAM_DST_EXT);
  assign fetchAddr = ptr_r;
  assign busy = (state_r != OAM_IDLE);
  assign done = (state_r == OAM_DONE);
  assign unsupportedMode = badMode_r;
  assign srcIsMem = srcMem_r;
  assign dstIsMem = dstMem_r;
  assign srcAddr = srcAddr_r;
  assign dstAddr = dstAddr_r;
  assign nextPc = ptr_r;
  assign instrWords = words_r;
  assign resultData = resultData_r;
  assign flagN = flagN_r;
  assign flagZ = flagZ_r;
  assign flagC = flagC_r;
  assign flagV = flagV_r;

endmodule

// >>> verif/oam_operand_addr_monitor.sv
// concurrent checks on the ports of the operand address block
`timescale 1ns/1ps
module oam_operand_addr_monitor (
  input wire logic mclk, nrst, ce, start, busy, done, fetchReq, fetchAck, srcIsMem, dstIsMem,
  input wire logic dstModeBit, resultValid, byteOp, carryByte, flagN, flagZ, flagC,
  input wire logic [1:0] sourceModeField, instrWords,
  input wire logic [15:0] instrPc, srcRegVal, dstRegVal, fetchAddr, srcAddr, dstAddr,
  input wire logic [15:0] aluResult, resultData
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire startTaken = start && ce && !busy;
  wire byteStrobe = resultValid && ce && byteOp;
  property p_hi; byteStrobe |=> resultData[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("byte result high half set");
  property p_nc;
    byteStrobe |=> flagN == $past(aluResult[7]) && flagC == $past(carryByte);
  endproperty
  a_nc: assert property (p_nc) else $error("byte sign or carry flag");
  property p_z; byteStrobe |=> flagZ == ($past(aluResult[7:0]) == 8'h00); endproperty
  a_z: assert property (p_z) else $error("byte zero flag");
  property p_sr;
    startTaken && sourceModeField == 2'h0 |=> srcAddr == $past(srcRegVal) && !srcIsMem;
  endproperty
  a_sr: assert property (p_sr) else $error("source register mode");
  property p_dr;
    startTaken && !dstModeBit |=> dstAddr == $past(dstRegVal) && !dstIsMem;
  endproperty
  a_dr: assert property (p_dr) else $error("destination register mode");
  // a frozen clock enable legally holds the request off for that cycle
  property p_f1;
    startTaken && sourceModeField == 2'h1 |=>
      (fetchReq || !ce) && fetchAddr == $past(instrPc) + 16'h0002;
  endproperty
  a_f1: assert property (p_f1) else $error("source word not fetched first");
  property p_nw; done |-> instrWords == 2'h1 + srcIsMem + dstIsMem; endproperty
  a_nw: assert property (p_nw) else $error("instruction length");
  property p_hold; fetchReq && !fetchAck |=> $stable(fetchAddr); endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved while waiting");
  c_three: cover property (done && instrWords == 2'h3);
  c_one: cover property (done && instrWords == 2'h1);
  c_byte: cover property (byteStrobe);
endmodule
////////////////////////////////////////////////////////////////
bind oam_operand_addr oam_operand_addr_monitor oam_operand_addr_monitor_inst (.*);

// >>> verif/oam_mem_model.sv
// program memory answering extension word fetches after a set wait
`timescale 1ns/1ps
module oam_mem_model (
  input wire logic mclk, nrst, fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic [3:0] waitCycles,
  output logic [15:0] fetchData,
  output logic fetchAck
);
  logic [15:0] mem [0:65535];
  int cnt;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fetchAck <= 1'b0;
      fetchData <= 16'h0000;
      cnt <= 0;
    end else if (fetchReq && !fetchAck && cnt < waitCycles) begin
      cnt <= cnt + 1;
    end else if (fetchReq && !fetchAck) begin
      fetchAck <= 1'b1;
      fetchData <= mem[fetchAddr];
      cnt <= 0;
    end else begin
      fetchAck <= 1'b0;
      // bus released: invert the held word each idle cycle, so the old word shows again every second cycle
      fetchData <= ~fetchData;
    end
  end
endmodule

// >>> verif/oam_operand_addr_tb.sv
// self-checking bench for the operand address block
`timescale 1ns/1ps
module oam_operand_addr_tb;
  import oam_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, start = 1'b0, dstModeBit = 1'b0, resultValid = 1'b0;
  logic byteOp = 1'b0, ce = 1'b1, carryWord = 1'b0, carryByte = 1'b1;
  logic overflowWord = 1'b1, overflowByte = 1'b0;
  logic [1:0] sourceModeField = 2'h0, instrWords;
  logic [3:0] srcRegSel = 4'h0, dstRegSel = 4'h0, waitCycles = 4'h0;
  logic [15:0] instrPc = 16'h0000, srcRegVal = 16'h0000, dstRegVal = 16'h0000;
  logic [15:0] aluResult = 16'h0000, fetchData, fetchAddr, srcAddr, dstAddr, nextPc, resultData;
  logic fetchReq, fetchAck, busy, done, unsupportedMode, srcIsMem, dstIsMem;
  logic flagN, flagZ, flagC, flagV;
  int mismatches = 0;
  int samples_checked = 0;
  oam_operand_addr oam_operand_addr_inst (.*);
  oam_mem_model memModel (.*);
  initial begin
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [15:0] pc, input logic [1:0] sm, input logic [3:0] sr,
      input logic [15:0] sv, input logic dm, input logic [3:0] dr, input logic [15:0] dv,
      input logic [15:0] ea, input logic [15:0] eb, input logic [1:0] nw);
    int n;
    n = 0;
    @(posedge mclk);
    instrPc <= pc;
    sourceModeField <= sm;
    srcRegSel <= sr;
    srcRegVal <= sv;
    dstModeBit <= dm;
    dstRegSel <= dr;
    dstRegVal <= dv;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    while (done !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk({14'h0000, done, busy}, 16'h0003);
    chk(srcAddr, ea);
    chk(dstAddr, eb);
    chk(nextPc, pc + {13'h0000, nw, 1'b0});
    chk({14'h0000, instrWords}, {14'h0000, nw});
  endtask
  task automatic res(input logic b, input logic [15:0] a, input logic [15:0] er,
      input logic [3:0] nzcv);
    @(posedge mclk);
    resultValid <= 1'b1;
    byteOp <= b;
    aluResult <= a;
    @(posedge mclk);
    resultValid <= 1'b0;
    @(negedge mclk);
    chk(resultData, er);
    chk({12'h000, flagN, flagZ, flagC, flagV}, {12'h000, nzcv});
  endtask
  task automatic t_modes;
    run(16'h0100, 2'h0, 4'h5, 16'hA023, 1'b0, 4'hB, 16'hFA15, 16'hA023, 16'hFA15, 2'h1);
    waitCycles <= 4'h3;
    memModel.mem[16'hFF14] = 16'h0002;
    memModel.mem[16'hFF16] = 16'h0006;
    run(16'hFF12, 2'h1, 4'h5, 16'h1080, 1'b1, 4'h6, 16'h108C, 16'h1082, 16'h1092, 2'h3);
    waitCycles <= 4'h0;
    memModel.mem[16'hFF14] = 16'hF102;
    memModel.mem[16'hFF16] = 16'h11FE;
    run(16'hFF12, 2'h1, 4'h0, 16'hFF12, 1'b1, 4'h0, 16'hFF12, 16'hF016, 16'h1114, 2'h3);
    memModel.mem[16'hFF14] = 16'hF016;
    memModel.mem[16'hFF16] = 16'h1114;
    run(16'hFF12, 2'h1, 4'h2, 16'h1234, 1'b1, 4'h2, 16'h5678, 16'hF016, 16'h1114, 2'h3);
    $display("mode tests done");
  endtask
  task automatic t_mixed;
    memModel.mem[16'h0202] = 16'h0010;
    memModel.mem[16'h0302] = 16'h0004;
    run(16'h0200, 2'h0, 4'h4, 16'h0400, 1'b1, 4'h7, 16'h3000, 16'h0400, 16'h3010, 2'h2);
    run(16'h0300, 2'h1, 4'h4, 16'h0400, 1'b0, 4'h7, 16'h3000, 16'h0404, 16'h3000, 2'h2);
    chk({15'h0000, unsupportedMode}, 16'h0000);
    // an unsupported source field is flagged and handled as register mode
    run(16'h0400, 2'h2, 4'h4, 16'h0400, 1'b0, 4'h7, 16'h3000, 16'h0400, 16'h3000, 2'h1);
    chk({15'h0000, unsupportedMode}, 16'h0001);
    $display("mixed length tests done");
  endtask
  task automatic t_result;
    res(1'b1, 16'hA023, 16'h0023, 4'h2);
    res(1'b1, 16'h5500, 16'h0000, 4'h6);
    res(1'b1, 16'h0080, 16'h0080, 4'hA);
    res(1'b0, 16'h8000, 16'h8000, 4'h9);
    // with the clock enable low the strobe must leave result and flags alone
    @(posedge mclk);
    ce <= 1'b0;
    res(1'b1, 16'hA023, 16'h8000, 4'h9);
    ce <= 1'b1;
    $display("result tests done");
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    t_modes();
    t_mixed();
    t_result();
    stop_test();
  end
  // the tests need under a hundred cycles; this leaves ample margin
  initial begin
    #20000;
    mismatches++;
    stop_test();
  end
endmodule
